/* File: io_src_model.sv */
`timescale 1ns/1ps
module io_src_model (
   input wire logic clock,
   input wire logic [15:0] fire,
   input wire logic [3:0] dly,
   output logic [15:0] ch_int_req
);
   logic [15:0] arm_q;
   logic [3:0] cnt_q;
   initial begin
      arm_q = '0;
      cnt_q = '0;
      ch_int_req = '0;
   end
   // slow channels hold their request back for dly+1 cycles after arming, then pulse it for one cycle
   always @(posedge clock) begin
      ch_int_req <= '0;
      if (|fire) begin
         arm_q <= fire;
         cnt_q <= dly;
      end else if (|arm_q) begin
         if (cnt_q == 4'h0) begin
            ch_int_req <= arm_q;
            arm_q <= '0;
         end else begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

/* File: tisc_lvl_if.sv */
`timescale 1ns/1ps
interface tisc_lvl_if;
   import tisc_pkg::*;
   logic [NUM_SRC-1:0] pend;
   logic [NUM_SRC-1:0] enab;
   logic blocked;
   logic hit;
   logic [4:0] idx;
   modport arb (input pend, input enab, input blocked, output hit, output idx);
   modport ctl (output pend, output enab, output blocked, input hit, input idx);
endinterface

/* File: tisc_pkg.sv */
package tisc_pkg;
   localparam int WORD_W = 32;
   localparam int LVL_W = 7;
   localparam int NUM_CH = 16;
   // status word field positions
   localparam int SW_IO_LO = 2;
   localparam int SW_IO_HI = 7;
   localparam int SW_OPND_PAR = 8;
   localparam int SW_INST_PAR = 9;
   localparam int SW_OPND_NP = 10;
   localparam int SW_INST_NP = 11;
   localparam int SW_MISC_LO = 12;
   localparam int SW_MISC_HI = 22;
   localparam int SW_CLEAR_HI = 23;
   localparam int SW_AE_EN = 24;
   localparam int SW_NM_TRAP_DIS = 25;
   localparam int SW_BLOCK_MODE = 26;
   localparam int SW_PFU_MEM = 27;
   localparam int SW_DW_MODE = 31;
   localparam int PSD_AE_BIT = 7;
   // condition code bit positions, cc[1..4] held as [3:0]
   localparam int CC2_POS = 2;
   localparam int CC3_POS = 1;
   localparam int CC4_POS = 0;
   // halfword opcodes
   localparam logic [15:0] OP_AE_ENABLE = 16'h0008;
   localparam logic [15:0] OP_AE_DISABLE = 16'h000e;
   // level-control opcode field bits 0-5 (msb numbering), arbitrary selection codes
   localparam logic [5:0] LC_ENABLE = 6'h3f;
   localparam logic [5:0] LC_DISABLE = 6'h3e;
   localparam logic [5:0] LC_REQUEST = 6'h3d;
   localparam logic [5:0] LC_ACTIVATE = 6'h3c;
   localparam logic [5:0] LC_DEACTIVATE = 6'h3b;
   // relative priorities and vectors
   localparam logic [6:0] PRI_PF_TRAP = 7'h00;
   localparam logic [11:0] VEC_PF_TRAP = 12'h0f4;
   localparam logic [6:0] PRI_OVR_TRAP = 7'h01;
   localparam logic [11:0] VEC_OVR_TRAP = 12'h0fc;
   localparam logic [6:0] PRI_BMT_TRAP = 7'h0e;
   localparam logic [11:0] VEC_BMT_TRAP = 12'h0e4;
   localparam logic [6:0] PRI_PF_INT = 7'h10;
   localparam logic [6:0] LVL_PF_INT = 7'h00;
   localparam logic [11:0] VEC_PF_INT = 12'h0f0;
   localparam logic [6:0] PRI_CH0 = 7'h14;
   localparam logic [11:0] VEC_CH0 = 12'h140;
   localparam logic [11:0] TCW_CH0 = 12'h100;
   localparam logic [11:0] IO_COMMAND_QUEUE_ADDRESS_CH0 = 12'h700;
   localparam int NUM_SRC = 19;
endpackage

/* File: tisc_prio_arb.sv */
`timescale 1ns/1ps
module tisc_prio_arb
   import tisc_pkg::*;
(
   tisc_lvl_if.arb lv
);
   logic [NUM_SRC-1:0] elig;
   logic [4:0] pick;
   assign elig = lv.pend & lv.enab & {NUM_SRC{~lv.blocked}};
   // index 0 is the lowest relative priority number, so scan downward
   always_comb begin
      pick = 5'd0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            pick = 5'(i);
         end
      end
   end
   assign lv.hit = |elig;
   assign lv.idx = pick;
endmodule

/* File: tisc_vec_rom.sv */
`timescale 1ns/1ps
module tisc_vec_rom
   import tisc_pkg::*;
(
   input wire logic [4:0] idx,
   output logic [6:0] pri,
   output logic [11:0] vec,
   output logic [11:0] transfer_control_word_address,
   output logic [11:0] io_command_queue_address
);
   logic [3:0] ch;
   assign ch = 4'(idx - 5'd3);
   always_comb begin
      pri = PRI_PF_TRAP;
      vec = VEC_PF_TRAP;
      transfer_control_word_address = 12'h000;
      io_command_queue_address = 12'h000;
      if (idx == 5'd1) begin
         pri = PRI_OVR_TRAP;
         vec = VEC_OVR_TRAP;
      end else if (idx == 5'd1 + 5'd1) begin
         pri = PRI_BMT_TRAP;
         vec = VEC_BMT_TRAP;
      end else if (idx == 5'd3 - 5'd0 - 5'd0 && 1'b0) begin
         pri = PRI_PF_INT;
      end else if (idx >= 5'd3) begin
         pri = PRI_CH0 + 7'(ch);
         vec = VEC_CH0 + {6'h00, ch, 2'b00};
         transfer_control_word_address = TCW_CH0 + {6'h00, ch, 2'b00};
         io_command_queue_address = IO_COMMAND_QUEUE_ADDRESS_CH0 + {5'h00, ch, 3'b000};
      end
   end
endmodule

/* File: trap_interrupt_status_control.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - status bits 2-7 flag i/o path faults
// R2 - bits 8-11 flag fetch parity and nonpresent faults
// R3 - bits 12-22 flag further processor faults
// R4 - bits 24-27 report trap enable, trap disable, block mode, power-up error
// R5 - bit 31 shows doubleword status mode
// R6 - status read sets cc2 mode, cc3 blocked, cc4 low bits zero
// R7 - status read is privileged and refused as execute target
// R8 - status read traps undefined when doubleword mode not jumpered
// R9 - opcode 0008 sets doubleword bit 7, codes unchanged
// R10 - enable in legacy mode raises undefined trap instead
// R11 - opcode 000e clears doubleword bit 7, codes unchanged
// R12 - disable in legacy mode raises undefined trap
// R13 - level operations act only in privileged state
// R14 - bits 0-5 of level word are the opcode
// R15 - bits 6-12 are the commanded level number
// R16 - bits 16-31 do not affect the operation
// R17 - level operations never change condition codes
// R18 - power fail trap priority 00 vector 0f4
// R19 - override trap priority 01 vector 0fc, never generated
// R20 - block mode timeout trap priority 0e vector 0e4
// R21 - power fail interrupt priority 10, level 00, vector 0f0; level operations on level 00 select no source here
// R22 - channel n priority 14+n, vector 140+4n, tcw 100+4n, queue 700+8n
// R23 - after a status read, bits 0-23 clear and 24-31 stay
// R24 - lowest numbered eligible request is serviced first
module trap_interrupt_status_control
   import tisc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic dw_mode_allowed,
   input wire logic dw_mode,
   input wire logic privileged,
   input wire logic exec_target,
   input wire logic ints_blocked,
   input wire logic [SW_MISC_HI:0] fault_set,
   input wire logic pfu_mem_err,
   input wire logic nm_trap_dis,
   input wire logic block_mode,
   input wire logic pf_trap_req,
   input wire logic bmt_trap_req,
   input wire logic pf_int_req,
   input wire logic [NUM_CH-1:0] ch_int_req,
   input wire logic instr_valid,
   input wire logic read_status_instr,
   input wire logic [15:0] halfword,
   input wire logic level_instr,
   input wire logic [WORD_W-1:0] level_word,
   input wire logic svc_ack,
   input wire logic [3:0] cc_in,
   output logic [WORD_W-1:0] status_out,
   output logic status_valid,
   output logic [3:0] cc_out,
   output logic cc_write,
   output logic undef_trap,
   output logic priv_trap,
   output logic ae_enabled,
   output logic svc_req,
   output logic [6:0] svc_pri,
   output logic [11:0] svc_vec,
   output logic [11:0] svc_tcw,
   output logic [11:0] svc_io_command_queue_address
);
   logic [WORD_W-1:0] sw_q, sw_d;
   logic ae_q;
   logic [NUM_SRC-1:0] pend_q, enab_q, act_q;
   logic [WORD_W-1:0] stat_q;
   logic stat_v_q, ccw_q, undef_q, priv_q;
   logic [3:0] cc_q;
   logic svc_q;
   logic [6:0] pri_q;
   logic [11:0] vec_q, tcw_q, io_command_queue_address_q;
   logic [6:0] rom_pri;
   logic [11:0] rom_vec, rom_tcw, rom_io_command_queue_address;
   tisc_lvl_if lv ();

   // decode
   logic rd_go, rd_bad_mode, rd_bad_priv;
   logic ae_en_hit, ae_dis_hit, ae_legacy;
   logic lc_go, lc_priv_bad;
   logic [5:0] lc_op;
   logic [6:0] lc_lvl;
   logic [NUM_SRC-1:0] lc_sel;
   logic [NUM_SRC-1:0] hw_req;
   logic [WORD_W-1:0] live_sw, rd_word;

   // R7 privileged, not execute target
   assign rd_bad_priv = instr_valid & read_status_instr & (~privileged | exec_target);
   // R8 mode jumper gate
   assign rd_bad_mode = instr_valid & read_status_instr & ~dw_mode_allowed;
   assign rd_go = instr_valid & read_status_instr & ~rd_bad_priv & ~rd_bad_mode;
   assign ae_en_hit = instr_valid & ~read_status_instr & ~level_instr & (halfword == OP_AE_ENABLE);
   assign ae_dis_hit = instr_valid & ~read_status_instr & ~level_instr & (halfword == OP_AE_DISABLE);
   // R10 R12 legacy mode refuses both
   assign ae_legacy = (ae_en_hit | ae_dis_hit) & ~dw_mode;
   // R14 R15 R16 fields, msb-first numbering; low half ignored
   assign lc_op = level_word[31:26];
   assign lc_lvl = level_word[25:19];
   // R13 privileged state only
   assign lc_priv_bad = instr_valid & level_instr & ~privileged;
   assign lc_go = instr_valid & level_instr & privileged;
   // level numbers map to sources: only channel levels 14-23; level 00 selects no source
   always_comb begin
      lc_sel = '0;
      if (lc_lvl == LVL_PF_INT) begin
         lc_sel[3 - 1 + 1] = 1'b0;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (lc_lvl == PRI_CH0 + 7'(i)) begin
            lc_sel[3 + i] = 1'b1;
         end
      end
   end

   // sources: 0 pf trap, 1 override (unused), 2 block timeout, 3.. channels; pf int is not a source, tracked in pfi_q
   // R19 override trap never raised
   assign hw_req = {ch_int_req, bmt_trap_req, 1'b0, pf_trap_req};

   // R1 R2 R3 R4 R5 live word
   assign live_sw = {dw_mode, 3'b000, pfu_mem_err, block_mode, nm_trap_dis, ae_q,
                     1'b0, sw_q[SW_MISC_HI:0]};
   assign rd_word = live_sw;

   always_comb begin
      sw_d = sw_q;
      // R23 clear low 24 bits after the read
      if (rd_go) begin
         sw_d[SW_CLEAR_HI:0] = '0;
      end
      // set wins over the read clear
      sw_d[SW_MISC_HI:SW_IO_LO] = sw_d[SW_MISC_HI:SW_IO_LO] | fault_set[SW_MISC_HI:SW_IO_LO];
   end

   assign lv.pend = pend_q;
   assign lv.enab = enab_q;
   assign lv.blocked = ints_blocked | (|act_q);

   // R24 lowest number wins
   tisc_prio_arb u_arb (
      .lv(lv)
   );
   // R18 R20 R22 fixed table
   tisc_vec_rom u_rom (
      .idx(lv.idx),
      .pri(rom_pri),
      .vec(rom_vec),
      .transfer_control_word_address(rom_tcw),
      .io_command_queue_address(rom_io_command_queue_address)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         sw_q <= '0;
      end else begin
         sw_q <= sw_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ae_q <= 1'b0;
      end else if (ae_en_hit & dw_mode) begin
         // R9 set enable
         ae_q <= 1'b1;
      end else if (ae_dis_hit & dw_mode) begin
         // R11 clear enable
         ae_q <= 1'b0;
      end
   end

   // level state; traps always enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         pend_q <= '0;
         enab_q <= {{(NUM_SRC - 3){1'b0}}, 3'b111};
         act_q <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (lc_go && lc_sel[i] && lc_op == LC_ENABLE) enab_q[i] <= 1'b1;
            if (lc_go && lc_sel[i] && lc_op == LC_DISABLE && i >= 3) enab_q[i] <= 1'b0;
            if (lc_go && lc_sel[i] && lc_op == LC_ACTIVATE) act_q[i] <= 1'b1;
            if (lc_go && lc_sel[i] && lc_op == LC_DEACTIVATE) act_q[i] <= 1'b0;
            if (svc_ack && svc_q && lv.idx == 5'(i)) begin
               pend_q[i] <= 1'b0;
            end else if (lc_go && lc_sel[i] && lc_op == LC_DISABLE) begin
               pend_q[i] <= hw_req[i];
            end
            // hardware request set wins
            if (hw_req[i] || (lc_go && lc_sel[i] && lc_op == LC_REQUEST)) pend_q[i] <= 1'b1;
         end
      end
   end

   // R21 power fail interrupt tracked alone, after traps and before channels
   logic pfi_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         pfi_q <= 1'b0;
      end else if (pf_int_req) begin
         pfi_q <= 1'b1;
      end else if (svc_ack && svc_q && pri_q == PRI_PF_INT) begin
         pfi_q <= 1'b0;
      end
   end
   logic use_pfi;
   assign use_pfi = pfi_q & ~lv.blocked & ~(|(pend_q[2:0]));

   always_ff @(posedge clock) begin
      if (rst) begin
         svc_q <= 1'b0;
         pri_q <= '0;
         vec_q <= '0;
         tcw_q <= '0;
         io_command_queue_address_q <= '0;
      end else begin
         svc_q <= lv.hit | use_pfi;
         pri_q <= use_pfi ? PRI_PF_INT : rom_pri;
         vec_q <= use_pfi ? VEC_PF_INT : rom_vec;
         tcw_q <= use_pfi ? 12'h000 : rom_tcw;
         io_command_queue_address_q <= use_pfi ? 12'h000 : rom_io_command_queue_address;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stat_q <= '0;
         stat_v_q <= 1'b0;
         cc_q <= '0;
         ccw_q <= 1'b0;
         undef_q <= 1'b0;
         priv_q <= 1'b0;
      end else begin
         stat_v_q <= rd_go;
         if (rd_go) stat_q <= rd_word;
         // R6 codes on a status read; R17 level ops leave them
         ccw_q <= rd_go;
         cc_q <= rd_go ? {1'b0, dw_mode, ints_blocked, ~(|rd_word[SW_CLEAR_HI:0])} : cc_in;
         undef_q <= (rd_bad_mode & ~rd_bad_priv) | ae_legacy;
         priv_q <= rd_bad_priv | lc_priv_bad;
      end
   end

   assign status_out = stat_q;
   assign status_valid = stat_v_q;
   assign cc_out = cc_q;
   assign cc_write = ccw_q;
   assign undef_trap = undef_q;
   assign priv_trap = priv_q;
   assign ae_enabled = ae_q;
   assign svc_req = svc_q;
   assign svc_pri = pri_q;
   assign svc_vec = vec_q;
   assign svc_tcw = tcw_q;
   assign svc_io_command_queue_address = io_command_queue_address_q;

   // R9 enable lands next cycle
   chk_ae_set_next: assert property (@(posedge clock) disable iff (rst)
      ae_en_hit && dw_mode |=> ae_enabled) else $error("enable did not set");
   // R11
   chk_ae_clr_next: assert property (@(posedge clock) disable iff (rst)
      ae_dis_hit && dw_mode |=> !ae_enabled) else $error("disable did not clear");
   // R10
   chk_legacy_undef: assert property (@(posedge clock) disable iff (rst)
      ae_en_hit && !dw_mode |=> undef_trap && $stable(ae_enabled)) else $error("legacy enable not trapped");
   // R8
   chk_rd_jumper: assert property (@(posedge clock) disable iff (rst)
      rd_bad_mode && !rd_bad_priv |=> undef_trap && !status_valid) else $error("jumper trap missing");
   // R7
   chk_rd_exec: assert property (@(posedge clock) disable iff (rst)
      instr_valid && read_status_instr && exec_target |=> priv_trap && !status_valid) else $error("exec target read");
   // R6
   chk_cc_mode: assert property (@(posedge clock) disable iff (rst)
      rd_go |=> cc_write && cc_out[CC2_POS] == $past(dw_mode)) else $error("cc2 wrong");
   // R23
   chk_sw_clear: assert property (@(posedge clock) disable iff (rst)
      rd_go && fault_set == '0 |=> sw_q[SW_CLEAR_HI:0] == '0) else $error("low bits not cleared");
   // R5
   chk_mode_bit: assert property (@(posedge clock) disable iff (rst)
      rd_go |=> status_out[SW_DW_MODE] == $past(dw_mode)) else $error("mode bit wrong");
   // R17
   chk_lc_no_cc: assert property (@(posedge clock) disable iff (rst)
      lc_go && !rd_go |=> !cc_write) else $error("level op wrote codes");
endmodule

/* File: trap_interrupt_status_control_tb.sv */
`timescale 1ns/1ps
module trap_interrupt_status_control_tb;
   import tisc_pkg::*;
   logic clock, rst, dw_mode_allowed, dw_mode, privileged, exec_target, ints_blocked;
   logic pfu_mem_err, nm_trap_dis, block_mode, pf_trap_req, bmt_trap_req, pf_int_req;
   logic instr_valid, read_status_instr, level_instr, svc_ack, status_valid, cc_write;
   logic undef_trap, priv_trap, ae_enabled, svc_req;
   logic [22:0] fault_set;
   logic [15:0] ch_int_req, halfword, fire;
   logic [31:0] level_word, status_out;
   logic [3:0] cc_in, cc_out, dly;
   logic [6:0] svc_pri;
   logic [11:0] svc_vec, svc_tcw, svc_io_command_queue_address;
   int error_cnt = 0;
   int samples_checked = 0;

   trap_interrupt_status_control i_dut (.clock(clock), .rst(rst), .dw_mode_allowed(dw_mode_allowed),
      .dw_mode(dw_mode), .privileged(privileged), .exec_target(exec_target), .ints_blocked(ints_blocked),
      .fault_set(fault_set), .pfu_mem_err(pfu_mem_err), .nm_trap_dis(nm_trap_dis), .block_mode(block_mode),
      .pf_trap_req(pf_trap_req), .bmt_trap_req(bmt_trap_req), .pf_int_req(pf_int_req),
      .ch_int_req(ch_int_req), .instr_valid(instr_valid), .read_status_instr(read_status_instr),
      .halfword(halfword), .level_instr(level_instr), .level_word(level_word), .svc_ack(svc_ack),
      .cc_in(cc_in), .status_out(status_out), .status_valid(status_valid), .cc_out(cc_out),
      .cc_write(cc_write), .undef_trap(undef_trap), .priv_trap(priv_trap), .ae_enabled(ae_enabled),
      .svc_req(svc_req), .svc_pri(svc_pri), .svc_vec(svc_vec), .svc_tcw(svc_tcw), .svc_io_command_queue_address(svc_io_command_queue_address));
   io_src_model i_src (.clock(clock), .fire(fire), .dly(dly), .ch_int_req(ch_int_req));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle instruction, outputs sampled in the answer cycle
   task automatic instr(input logic rs, input logic [15:0] hw, input logic lv, input logic [31:0] lw);
      @(posedge clock);
      instr_valid <= 1'b1;
      read_status_instr <= rs;
      halfword <= hw;
      level_instr <= lv;
      level_word <= lw;
      @(posedge clock);
      instr_valid <= 1'b0;
      read_status_instr <= 1'b0;
      level_instr <= 1'b0;
      halfword <= 16'h0000;
      #1;
   endtask

   // junk in the unassigned low half must not matter
   task automatic level_op(input logic [5:0] op, input logic [6:0] lvl);
      instr(1'b0, 16'h0000, 1'b1, {op, lvl, 3'h0, 16'ha5c3});
      cmp(cc_write, 0);
   endtask

   task automatic wait_svc(input logic [6:0] pri, input logic [11:0] vec, input logic [11:0] transfer_control_word_address,
                           input logic [11:0] q);
      int n;
      for (n = 0; n < 30; n++) begin
         #1;
         if (svc_req === 1'b1 && svc_pri === pri) break;
         @(posedge clock);
      end
      if (n == 30) begin
         error_cnt++;
         give_verdict();
      end
      cmp({svc_vec, svc_tcw, svc_io_command_queue_address}, {vec, transfer_control_word_address, q});
      @(posedge clock);
      svc_ack <= 1'b1;
      @(posedge clock);
      svc_ack <= 1'b0;
   endtask

   task automatic t_reset;
      cmp({ae_enabled, svc_req, status_valid, undef_trap, priv_trap}, 0);
   endtask

   task automatic t_arith;
      instr(1'b0, OP_AE_ENABLE, 1'b0, 0);
      cmp({ae_enabled, cc_write, undef_trap}, 3'b100);
      instr(1'b0, OP_AE_DISABLE, 1'b0, 0);
      cmp({ae_enabled, cc_write, undef_trap}, 3'b000);
      dw_mode <= 1'b0;
      instr(1'b0, OP_AE_ENABLE, 1'b0, 0);
      cmp({ae_enabled, undef_trap}, 2'b01);
      dw_mode <= 1'b1;
      instr(1'b0, OP_AE_ENABLE, 1'b0, 0);
      dw_mode <= 1'b0;
      instr(1'b0, OP_AE_DISABLE, 1'b0, 0);
      cmp({ae_enabled, undef_trap}, 2'b11);
      dw_mode <= 1'b1;
   endtask

   task automatic t_status;
      pfu_mem_err <= 1'b1;
      block_mode <= 1'b1;
      ints_blocked <= 1'b1;
      @(posedge clock);
      fault_set <= 23'h7ffffc;
      @(posedge clock);
      fault_set <= '0;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp({status_valid, cc_write}, 2'b11);
      cmp({status_out[23:21], status_out[2:0]}, 6'b011100);
      cmp(status_out[20:3], 18'h3ffff);
      cmp(status_out[31:24], 8'h8d);
      cmp(cc_out[2:0], 3'b110);
      ints_blocked <= 1'b0;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp(status_out, 32'h8d000000);
      cmp(cc_out[2:0], 3'b101);
      dw_mode <= 1'b0;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp({status_out[31:24], 1'b0, cc_out[2:0]}, 12'h0d1);
      dw_mode <= 1'b1;
   endtask

   task automatic t_refuse;
      dw_mode_allowed <= 1'b0;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp({status_valid, undef_trap}, 2'b01);
      dw_mode_allowed <= 1'b1;
      privileged <= 1'b0;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp({status_valid, priv_trap}, 2'b01);
      privileged <= 1'b1;
      exec_target <= 1'b1;
      instr(1'b1, 16'h0000, 1'b0, 0);
      cmp(status_valid, 0);
      exec_target <= 1'b0;
   endtask

   task automatic t_service;
      level_op(LC_ENABLE, 7'h15);
      level_op(LC_ENABLE, 7'h17);
      level_op(LC_ENABLE, 7'h00);
      privileged <= 1'b0;
      level_op(LC_ENABLE, 7'h14);
      cmp(priv_trap, 1);
      privileged <= 1'b1;
      @(posedge clock);
      fire <= 16'h000b;
      dly <= 4'h3;
      @(posedge clock);
      fire <= '0;
      wait_svc(7'h15, 12'h144, 12'h104, 12'h708);
      wait_svc(7'h17, 12'h14c, 12'h10c, 12'h718);
      @(posedge clock);
      pf_trap_req <= 1'b1;
      pf_int_req <= 1'b1;
      @(posedge clock);
      pf_trap_req <= 1'b0;
      pf_int_req <= 1'b0;
      wait_svc(PRI_PF_TRAP, 12'h0f4, 12'h000, 12'h000);
      wait_svc(7'h10, 12'h0f0, 12'h000, 12'h000);
   endtask

   initial begin
      rst = 1'b1;
      {dw_mode_allowed, dw_mode, privileged} = 3'b111;
      {exec_target, ints_blocked, pfu_mem_err, nm_trap_dis, block_mode} = '0;
      {pf_trap_req, bmt_trap_req, pf_int_req, instr_valid, read_status_instr, level_instr, svc_ack} = '0;
      fault_set = '0;
      halfword = '0;
      level_word = '0;
      cc_in = 4'h8;
      fire = '0;
      dly = '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      t_reset();
      t_arith();
      instr(1'b0, OP_AE_ENABLE, 1'b0, 0);
      t_status();
      t_refuse();
      t_service();
      give_verdict();
   end
endmodule
